//--- design/uhpm_pkg.sv
// Package with offsets, field positions and reset values for the host port and modem status block
// Overview of operation
// - Three-bit select picks register each access
// - Strobe low passes selects; rising edge latches
// - Selected only when hi_a, hi_b high, lo_n low
// - Output 16x clock: reference divided by divisor
// - Status bit 4 clear-to-send, bit 0 change
// - CTS change interrupts unless auto-CTS enabled
// - Auto-CTS lets clear-to-send gate transmitter
// - Status bit 7 carrier, bit 3 change
// - Status bit 5 data-set-ready, bit 1 change
// - Carrier or DSR change interrupts when enabled
// - Eight-bit bus driven only during reads
// - Driver disable high whenever no read
// - Terminal-ready low when bit set, not loop
// - Interrupt high while any enabled source pending
// - Interrupt drops when serviced or reset
// - Master reset clears registers, sets outputs
package uhpm_pkg;
   // Register indices on the three select lines
   localparam logic [2:0] UHPM_IDX_DIV_LO = 3'h0;
   localparam logic [2:0] UHPM_IDX_IER = 3'h1;
   localparam logic [2:0] UHPM_IDX_DIV_HI = 3'h1;
   localparam logic [2:0] UHPM_IDX_LCR = 3'h3;
   localparam logic [2:0] UHPM_IDX_MCR = 3'h4;
   localparam logic [2:0] UHPM_IDX_MSR = 3'h6;
   // Interrupt enable fields
   localparam int UHPM_IER_RXD = 0;
   localparam int UHPM_IER_THRE = 1;
   localparam int UHPM_IER_RLS = 2;
   localparam int UHPM_IER_MSI = 3;
   // Line control: divisor access bit
   localparam int UHPM_LCR_DLAB = 7;
   // Modem control fields
   localparam int UHPM_MCR_DTR = 0;
   localparam int UHPM_MCR_RTS = 1;
   localparam int UHPM_MCR_LOOP = 4;
   localparam int UHPM_MCR_AFE = 5;
   // Modem status fields
   localparam int UHPM_MSR_DCTS = 0;
   localparam int UHPM_MSR_DDSR = 1;
   localparam int UHPM_MSR_DDCD = 3;
   localparam int UHPM_MSR_CTS = 4;
   localparam int UHPM_MSR_DSR = 5;
   localparam int UHPM_MSR_DCD = 7;
   // Reset values
   localparam logic [7:0] UHPM_RST_REG = 8'h00;
   localparam logic [15:0] UHPM_RST_DIV = 16'h0000;
   localparam logic [7:0] UHPM_READ_ZERO = 8'h00;
   // Synchroniser depth for pin inputs
   localparam int UHPM_SYNC_STAGES = 3;
endpackage

//--- design/uhpm_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module uhpm_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Raw pins and filtered levels
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o
);
   import uhpm_pkg::*;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic s1_q; // First stage, read only by the second
         logic s2_q; // Second stage
         logic s3_q; // Third stage
         logic lvl_q; // Accepted level

         // Shift chain
         always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
               s1_q <= RST_VAL[gi];
               s2_q <= RST_VAL[gi];
               s3_q <= RST_VAL[gi];
            end else begin
               s1_q <= pin_i[gi];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end

         // Accept a new level when the last two stages agree
         always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
               lvl_q <= RST_VAL[gi];
            end else if (s2_q == s3_q) begin
               lvl_q <= s3_q;
            end
         end

         assign level_o[gi] = lvl_q;
      end
   endgenerate
endmodule

//--- design/uhpm_host_modem.sv
// Host bus decode, modem status tracking, divisor clock and interrupt output of the serial unit
`timescale 1ns/100ps
module uhpm_host_modem (
   // Clock and master reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Host select pins
   input wire logic reg_sel_bit0_i,
   input wire logic reg_sel_bit1_i,
   input wire logic reg_sel_bit2_i,
   input wire logic addr_strobe_n_i,
   input wire logic chip_sel_hi_a_i,
   input wire logic chip_sel_hi_b_i,
   input wire logic chip_sel_lo_n_i,
   // Host strobes, active high
   input wire logic host_rd_i,
   input wire logic host_wr_i,
   // Host data bus as three signals
   input wire logic [7:0] host_data_bus_i,
   output logic [7:0] host_data_bus_o,
   output logic host_data_bus_oe_o,
   output logic bus_driver_disable_o,
   // Modem status pins, active low
   input wire logic cts_n_i,
   input wire logic dsr_n_i,
   input wire logic dcd_n_i,
   // Modem control pin and transmitter gate
   output logic term_ready_n_o,
   output logic tx_send_allow_o,
   // Other interrupt sources, levels from the datapath
   input wire logic rx_error_i,
   input wire logic rx_data_avail_i,
   input wire logic rx_timeout_i,
   input wire logic thr_empty_i,
   // Interrupt and divided clock
   output logic irq_out_o,
   output logic tx_16x_clock_out_o
);
   import uhpm_pkg::*;

   // Pin bundle order, lowest bit first:
   //   [2:0]  register select lines
   //   [5:3]  chip select lines, two active high and one active low
   //   [7:6]  read and write strobes
   //   [8]    address strobe, active low
   //   [11:9] clear-to-send, data-set-ready, carrier detect, active low
   // Reset levels match an idle, deselected host and an inactive modem, so no
   // false strobe edge or false status change is seen as reset lets go.
   localparam int NPIN = 12; // Pins through the synchroniser
   localparam logic [NPIN-1:0] SYNC_RST = 12'hF00; // Strobe and modem pins high, rest low

   logic [NPIN-1:0] raw_pins; // Raw pin bundle
   logic [NPIN-1:0] pin_lvl; // Filtered pin levels
   logic [2:0] sel_now; // Register select as seen now
   logic cs_now; // Chip select decode as seen now
   logic ads_n_s; // Filtered address strobe
   logic rd_s; // Filtered read strobe
   logic wr_s; // Filtered write strobe
   logic cts_s; // Filtered clear-to-send, active high
   logic dsr_s; // Filtered data-set-ready, active high
   logic dcd_s; // Filtered carrier detect, active high
   logic [2:0] sel_q; // Latched register select
   logic cs_q; // Latched chip select decode
   logic [2:0] sel_use; // Select used by decode
   logic cs_use; // Chip select used by decode
   logic rd_prev_q; // Read strobe last cycle
   logic wr_prev_q; // Write strobe last cycle
   logic rd_rise; // Read start
   logic rd_fall; // Read end
   logic wr_rise; // Write start
   logic msr_rd_q; // Read in progress targets status
   logic [7:0] ier_q; // Interrupt enable register
   logic [7:0] lcr_q; // Line control register
   logic [7:0] mcr_q; // Modem control register
   logic [15:0] div_q; // Baud divisor latches
   logic [15:0] bcnt_q; // Baud divider count
   logic [15:0] bcnt_d; // Next divider count
   logic [15:0] half_div; // High phase length
   logic cts_prev_q; // Clear-to-send last cycle
   logic dsr_prev_q; // Data-set-ready last cycle
   logic dcd_prev_q; // Carrier detect last cycle
   logic dcts_q; // Clear-to-send change flag
   logic ddsr_q; // Data-set-ready change flag
   logic dcd_change_flag_q; // Carrier detect change flag
   logic [7:0] msr_val; // Modem status value
   logic [7:0] rd_val; // Value for the selected register
   logic modem_irq; // Enabled modem status interrupt
   logic irq_d; // Next interrupt level
   logic [7:0] data_q; // Read data driven on the bus
   logic oe_q; // Bus output enable
   logic bus_driver_disable_q; // Driver disable
   logic dtr_n_q; // Terminal-ready pin
   logic tx_allow_q; // Transmitter permission
   logic irq_q; // Interrupt pin
   logic baud_q; // Divided clock pin

   assign raw_pins = {
      dcd_n_i, dsr_n_i, cts_n_i, addr_strobe_n_i, host_wr_i, host_rd_i,
      chip_sel_lo_n_i, chip_sel_hi_b_i, chip_sel_hi_a_i,
      reg_sel_bit2_i, reg_sel_bit1_i, reg_sel_bit0_i
   };

   // All pins except the data bus pass the three-stage filter; the host strobes and selects come
   // from another bus, so they are treated as asynchronous like the modem pins.
   // The cost is about four clocks of latency on every access.
   uhpm_pin_sync #(
      .WIDTH(NPIN),
      .RST_VAL(SYNC_RST)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .pin_i(raw_pins),
      .level_o(pin_lvl)
   );

   assign sel_now = pin_lvl[2:0];
   assign cs_now = pin_lvl[3] & pin_lvl[4] & ~pin_lvl[5];
   assign rd_s = pin_lvl[6];
   assign wr_s = pin_lvl[7];
   assign ads_n_s = pin_lvl[8];
   assign cts_s = ~pin_lvl[9];
   assign dsr_s = ~pin_lvl[10];
   assign dcd_s = ~pin_lvl[11];

   // Select latch: follows while strobe low, holds while high
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sel_q <= 3'h0;
         cs_q <= 1'b0;
      end else if (!ads_n_s) begin
         sel_q <= sel_now;
         cs_q <= cs_now;
      end
   end

   // Strobe low passes the selects straight through
   assign sel_use = ads_n_s ? sel_q : sel_now;
   assign cs_use = ads_n_s ? cs_q : cs_now;

   // Strobe edge history
   // Edges are taken from filtered levels only, so one access gives exactly
   // one start and one end event however slowly the host moves its pins.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rd_prev_q <= 1'b0;
         wr_prev_q <= 1'b0;
      end else begin
         rd_prev_q <= rd_s;
         wr_prev_q <= wr_s;
      end
   end

   assign rd_rise = rd_s & ~rd_prev_q & cs_use;
   assign rd_fall = ~rd_s & rd_prev_q;
   assign wr_rise = wr_s & ~wr_prev_q & cs_use;

   // Host writes to the control registers
   // Write data is taken on the cycle the filtered write strobe rises; the host
   // must keep the data bus steady for the whole strobe.
   // The divisor shares indices 0 and 1 with other registers and is reached
   // only while the divisor access bit is set.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ier_q <= UHPM_RST_REG;
         lcr_q <= UHPM_RST_REG;
         mcr_q <= UHPM_RST_REG;
         div_q <= UHPM_RST_DIV;
      end else if (wr_rise) begin
         case (sel_use)
            UHPM_IDX_DIV_LO: begin
               if (lcr_q[UHPM_LCR_DLAB]) begin
                  div_q[7:0] <= host_data_bus_i;
               end
            end
            UHPM_IDX_IER: begin
               // Same index reaches the divisor high byte
               if (lcr_q[UHPM_LCR_DLAB]) begin
                  div_q[15:8] <= host_data_bus_i;
               end else begin
                  ier_q <= {4'h0, host_data_bus_i[3:0]};
               end
            end
            UHPM_IDX_LCR: begin
               lcr_q <= host_data_bus_i;
            end
            UHPM_IDX_MCR: begin
               mcr_q <= {2'h0, host_data_bus_i[5:0]};
            end
            default: begin
               // Other registers live in the datapath
            end
         endcase
      end
   end

   // Modem status as presented to the host
   always_comb begin
      msr_val = UHPM_READ_ZERO;
      msr_val[UHPM_MSR_CTS] = cts_s;
      msr_val[UHPM_MSR_DCTS] = dcts_q;
      msr_val[UHPM_MSR_DSR] = dsr_s;
      msr_val[UHPM_MSR_DDSR] = ddsr_q;
      msr_val[UHPM_MSR_DCD] = dcd_s;
      msr_val[UHPM_MSR_DDCD] = dcd_change_flag_q;
   end

   // Read mux for the selected register
   always_comb begin
      case (sel_use)
         UHPM_IDX_DIV_LO: rd_val = lcr_q[UHPM_LCR_DLAB] ? div_q[7:0] : UHPM_READ_ZERO;
         UHPM_IDX_IER: rd_val = lcr_q[UHPM_LCR_DLAB] ? div_q[15:8] : ier_q;
         UHPM_IDX_LCR: rd_val = lcr_q;
         UHPM_IDX_MCR: rd_val = mcr_q;
         UHPM_IDX_MSR: rd_val = msr_val;
         default: rd_val = UHPM_READ_ZERO;
      endcase
   end

   // Bus drive: enable and data only for the duration of a read
   // Read data is frozen at the start of the read so the host sees one value
   // even if a status pin moves while the strobe is held.
   // The transceiver disable is the exact opposite of the bus enable.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         data_q <= UHPM_READ_ZERO;
         oe_q <= 1'b0;
         bus_driver_disable_q <= 1'b1;
         msr_rd_q <= 1'b0;
      end else if (rd_rise) begin
         data_q <= rd_val;
         oe_q <= 1'b1;
         bus_driver_disable_q <= 1'b0;
         msr_rd_q <= (sel_use == UHPM_IDX_MSR);
      end else if (rd_fall) begin
         oe_q <= 1'b0;
         bus_driver_disable_q <= 1'b1;
         msr_rd_q <= 1'b0;
      end
   end

   // Previous modem levels for change detection
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cts_prev_q <= 1'b0;
         dsr_prev_q <= 1'b0;
         dcd_prev_q <= 1'b0;
      end else begin
         cts_prev_q <= cts_s;
         dsr_prev_q <= dsr_s;
         dcd_prev_q <= dcd_s;
      end
   end

   // Change flags: cleared at the end of a status read, a new change wins
   // Clearing at the end, not the start, also clears a change that arrives while the
   // host is reading, though the read data frozen at the start never showed it.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         dcts_q <= 1'b0;
         ddsr_q <= 1'b0;
         dcd_change_flag_q <= 1'b0;
      end else begin
         if (cts_s != cts_prev_q) begin
            dcts_q <= 1'b1;
         end else if (rd_fall && msr_rd_q) begin
            dcts_q <= 1'b0;
         end
         if (dsr_s != dsr_prev_q) begin
            ddsr_q <= 1'b1;
         end else if (rd_fall && msr_rd_q) begin
            ddsr_q <= 1'b0;
         end
         if (dcd_s != dcd_prev_q) begin
            dcd_change_flag_q <= 1'b1;
         end else if (rd_fall && msr_rd_q) begin
            dcd_change_flag_q <= 1'b0;
         end
      end
   end

   // Terminal-ready: active low when set, forced inactive in loop mode
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         dtr_n_q <= 1'b1;
      end else begin
         dtr_n_q <= ~(mcr_q[UHPM_MCR_DTR] & ~mcr_q[UHPM_MCR_LOOP]);
      end
   end

   // Auto-CTS gate; the remote must drop the line before the last stop bit
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tx_allow_q <= 1'b1;
      end else begin
         tx_allow_q <= ~mcr_q[UHPM_MCR_AFE] | cts_s;
      end
   end

   // Modem part of the interrupt
   // In auto flow mode the transmitter handles clear-to-send by itself, so its
   // change flag no longer disturbs the host.
   assign modem_irq = ier_q[UHPM_IER_MSI] &
      (dcd_change_flag_q | ddsr_q |
       (dcts_q & ~mcr_q[UHPM_MCR_AFE]));

   assign irq_d = modem_irq |
      (ier_q[UHPM_IER_RLS] & rx_error_i) |
      (ier_q[UHPM_IER_RXD] & (rx_data_avail_i | rx_timeout_i)) |
      (ier_q[UHPM_IER_THRE] & thr_empty_i);

   // Interrupt pin follows the pending sources and drops once serviced
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // Divider count wraps at divisor minus one
   // A zero divisor parks the counter and keeps the output low.
   // A divisor of one leaves the output steadily high.
   always_comb begin
      if (div_q == UHPM_RST_DIV || bcnt_q >= div_q - 16'h0001) begin
         bcnt_d = 16'h0000;
      end else begin
         bcnt_d = bcnt_q + 16'h0001;
      end
   end

   assign half_div = (div_q + 16'h0001) >> 1;

   // Divided 16x clock, high for the first half of each period
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         bcnt_q <= 16'h0000;
         baud_q <= 1'b0;
      end else begin
         bcnt_q <= bcnt_d;
         baud_q <= (div_q != UHPM_RST_DIV) && (bcnt_d < half_div);
      end
   end

   assign host_data_bus_o = data_q;
   assign host_data_bus_oe_o = oe_q;
   assign bus_driver_disable_o = bus_driver_disable_q;
   assign term_ready_n_o = dtr_n_q;
   assign tx_send_allow_o = tx_allow_q;
   assign irq_out_o = irq_q;
   assign tx_16x_clock_out_o = baud_q;
endmodule

//--- dv/uhpm_host_modem_monitor.sv
// Checker of host bus drive, select, reset and interrupt pin relations
`timescale 1ns/100ps
module uhpm_host_modem_monitor (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Host pins
   input wire logic addr_strobe_n_i,
   input wire logic chip_sel_hi_a_i,
   input wire logic chip_sel_hi_b_i,
   input wire logic chip_sel_lo_n_i,
   input wire logic host_rd_i,
   input wire logic host_wr_i,
   input wire logic host_data_bus_oe_o,
   input wire logic bus_driver_disable_o,
   // Modem and datapath pins
   input wire logic cts_n_i,
   input wire logic dsr_n_i,
   input wire logic dcd_n_i,
   input wire logic rx_error_i,
   input wire logic rx_data_avail_i,
   input wire logic rx_timeout_i,
   input wire logic thr_empty_i,
   // Outputs under watch
   input wire logic term_ready_n_o,
   input wire logic tx_send_allow_o,
   input wire logic irq_out_o,
   input wire logic tx_16x_clock_out_o
);
   // One clock domain, one reset
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   // Transceiver disable is always the opposite of our own bus drive
   property p_bus_driver_disable_oe;
      bus_driver_disable_o != host_data_bus_oe_o;
   endproperty
   a_bus_driver_disable_oe: assert property (p_bus_driver_disable_oe) else $error("driver disable not opposite of bus drive");
   // Bus drive only starts behind a read strobe
   property p_oe_cause;
      $rose(host_data_bus_oe_o) |-> $past(host_rd_i, 3);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("bus driven without a read");
   // Once driven, the bus stays driven for at least five cycles
   property p_oe_hold;
      $rose(host_data_bus_oe_o) |-> host_data_bus_oe_o [*5];
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("bus drive dropped early");
   // Read strobe gone means bus released within the filter delay
   property p_oe_drop;
      $fell(host_rd_i) |-> ##[3:7] !host_data_bus_oe_o;
   endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("bus not released after read");
   // Selected read gets the bus within the filter delay
   property p_rd_to_oe;
      $rose(host_rd_i) && !addr_strobe_n_i && chip_sel_hi_a_i && chip_sel_hi_b_i && !chip_sel_lo_n_i
         |-> ##[3:7] host_data_bus_oe_o;
   endproperty
   a_rd_to_oe: assert property (p_rd_to_oe) else $error("selected read not answered");
   // A device deselected by hi_a low, with the strobe open, never starts driving
   property p_unsel;
      (!addr_strobe_n_i && !chip_sel_hi_a_i) [*8] |-> !$rose(host_data_bus_oe_o);
   endproperty
   a_unsel: assert property (p_unsel) else $error("unselected device drove the bus");
   // Outputs leave reset at their defined levels
   property p_reset_vals;
      $fell(rst_i) |-> bus_driver_disable_o && !host_data_bus_oe_o && term_ready_n_o && !irq_out_o
         && !tx_16x_clock_out_o && tx_send_allow_o;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("output not at reset level");
   // With every cause quiet for a while, the interrupt cannot rise
   property p_irq_quiet;
      (!thr_empty_i && !rx_error_i && !rx_data_avail_i && !rx_timeout_i && !host_wr_i && $stable(cts_n_i)
         && $stable(dsr_n_i) && $stable(dcd_n_i)) [*8] |-> !$rose(irq_out_o);
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt rose without a cause");
endmodule

bind uhpm_host_modem uhpm_host_modem_monitor u_mon (.clk_sys_i, .rst_i, .addr_strobe_n_i, .chip_sel_hi_a_i,
   .chip_sel_hi_b_i, .chip_sel_lo_n_i, .host_rd_i, .host_wr_i, .host_data_bus_oe_o, .bus_driver_disable_o,
   .cts_n_i, .dsr_n_i, .dcd_n_i, .rx_error_i, .rx_data_avail_i, .rx_timeout_i, .thr_empty_i,
   .term_ready_n_o, .tx_send_allow_o, .irq_out_o, .tx_16x_clock_out_o);

//--- dv/uhpm_modem_model.sv
// Behavioural modem that drives the active-low status pins
`timescale 1ns/100ps
module uhpm_modem_model (
   // Clock
   input wire logic clk_sys_i,
   // Wanted levels, active high: bit0 clear-to-send, bit1 data-set-ready, bit2 carrier
   input wire logic [2:0] want_i,
   // Modem pins, active low
   output logic cts_n_o,
   output logic dsr_n_o,
   output logic dcd_n_o
);
   // Pins start inactive
   initial begin
      cts_n_o = 1'b1;
      dsr_n_o = 1'b1;
      dcd_n_o = 1'b1;
   end
   // Pins move just after an edge; clear-to-send follows want_i each clock like the other two
   always @(posedge clk_sys_i) begin
      cts_n_o <= ~want_i[0];
      dsr_n_o <= ~want_i[1];
      dcd_n_o <= ~want_i[2];
   end
endmodule

//--- dv/uhpm_host_modem_bench.sv
// Self-checking bench for the host port and modem status block
`timescale 1ns/100ps
module uhpm_host_modem_bench;
   import uhpm_pkg::*;
   // Host side pins and observed outputs
   logic clk_sys_i, rst_i, ads_n, cs_a, cs_b, cs_n, rd, wr;
   logic rxe, rxa, rxt, thr, cts_n, dsr_n, dcd_n, oe, bus_driver_disable, trn, allow, irq, baud;
   logic [2:0] sel, want;
   logic [7:0] wdat, rdat, hi;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   // Rows: {dcd,dsr,cts} wanted levels beside the status byte they should read as
   logic [10:0] rows [4] = '{11'h111, 11'h332, 11'h7B8, 11'h00B};
   // Enable needed for each datapath source: error, data, timeout, holding empty
   logic [7:0] ien [4] = '{8'h04, 8'h01, 8'h01, 8'h02};
   // Shared data wire: device drives it only while enabled
   wire logic [7:0] dbus = oe ? rdat : wdat;
   uhpm_host_modem dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_sel_bit0_i(sel[0]), .reg_sel_bit1_i(sel[1]),
      .reg_sel_bit2_i(sel[2]), .addr_strobe_n_i(ads_n), .chip_sel_hi_a_i(cs_a), .chip_sel_hi_b_i(cs_b),
      .chip_sel_lo_n_i(cs_n), .host_rd_i(rd), .host_wr_i(wr), .host_data_bus_i(dbus), .host_data_bus_o(rdat),
      .host_data_bus_oe_o(oe), .bus_driver_disable_o(bus_driver_disable), .cts_n_i(cts_n), .dsr_n_i(dsr_n), .dcd_n_i(dcd_n),
      .term_ready_n_o(trn), .tx_send_allow_o(allow), .rx_error_i(rxe), .rx_data_avail_i(rxa),
      .rx_timeout_i(rxt), .thr_empty_i(thr), .irq_out_o(irq), .tx_16x_clock_out_o(baud));
   uhpm_modem_model u_modem (.clk_sys_i(clk_sys_i), .want_i(want), .cts_n_o(cts_n), .dsr_n_o(dsr_n),
      .dcd_n_o(dcd_n));
   // Free-running 100 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Verdict and end of run
   task automatic finish_test();
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         finish_test();
      end
   end
   // Compare one value, unknowns never match
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   // Present a selected register index with the strobe open
   task automatic pick(logic [2:0] idx);
      sel = idx;
      ads_n = 1'b0;
      cs_a = 1'b1;
      tick(5);
   endtask
   // Write strobe held long enough for the pin filter, data stable throughout
   task automatic wreg(logic [2:0] idx, logic [7:0] d);
      pick(idx);
      wdat = d;
      wr = 1'b1;
      tick(6);
      wr = 1'b0;
      tick(6);
   endtask
   // Read: look for the bus drive under a bound, check data and the disable pin
   task automatic rreg(string what, logic drive, logic [7:0] exp);
      logic seen;
      seen = 1'b0;
      rd = 1'b1;
      for (int i = 0; i < 12 && !seen; i++) begin
         tick(1);
         seen = (oe === 1'b1);
      end
      chk({what, " drive"}, {7'h00, drive}, {7'h00, seen});
      if (seen) begin
         chk(what, exp, rdat);
         chk("bus_driver_disable reading", 8'h00, {7'h00, bus_driver_disable});
      end
      tick(3);
      rd = 1'b0;
      tick(8);
      chk("bus_driver_disable idle", 8'h01, {7'h00, bus_driver_disable});
   endtask
   // Main sequence
   initial begin
      rst_i = 1'b1;
      {ads_n, cs_a, cs_b, cs_n, rd, wr, rxe, rxa, rxt, thr} = 10'h000;
      {sel, want, wdat} = 14'h0000;
      cs_a = 1'b1;
      cs_b = 1'b1;
      tick(3);
      chk("reset outs", 8'h2C, {2'h0, bus_driver_disable, oe, trn, allow, irq, baud});
      rst_i = 1'b0;
      pick(UHPM_IDX_MSR);
      foreach (rows[i]) begin
         want = rows[i][10:8];
         tick(10);
         rreg("msr row", 1'b1, rows[i][7:0]);
      end
      rreg("msr reread", 1'b1, 8'h00);
      pick(3'h7);
      rreg("unmapped", 1'b1, 8'h00);
      cs_a = 1'b0;
      tick(5);
      rreg("unselected", 1'b0, 8'h00);
      wreg(UHPM_IDX_MCR, 8'h01);
      chk("dtr set", 8'h00, {7'h00, trn});
      pick(UHPM_IDX_MCR);
      rreg("mcr", 1'b1, 8'h01);
      wreg(UHPM_IDX_MCR, 8'h11);
      chk("dtr loop", 8'h01, {7'h00, trn});
      wreg(UHPM_IDX_MCR, 8'h20);
      chk("dtr clear", 8'h01, {7'h00, trn});
      chk("gate closed", 8'h00, {7'h00, allow});
      want = 3'h1;
      tick(10);
      chk("gate open", 8'h01, {7'h00, allow});
      wreg(UHPM_IDX_IER, 8'h08);
      want = 3'h0;
      tick(10);
      chk("irq auto cts", 8'h00, {7'h00, irq});
      chk("gate reclosed", 8'h00, {7'h00, allow});
      pick(UHPM_IDX_MSR);
      rreg("msr cts twice", 1'b1, 8'h01);
      want = 3'h4;
      tick(10);
      chk("irq dcd", 8'h01, {7'h00, irq});
      rreg("msr dcd", 1'b1, 8'h88);
      chk("irq dcd served", 8'h00, {7'h00, irq});
      want = 3'h6;
      tick(10);
      chk("irq dsr", 8'h01, {7'h00, irq});
      rreg("msr dsr", 1'b1, 8'hA2);
      chk("irq dsr served", 8'h00, {7'h00, irq});
      wreg(UHPM_IDX_MCR, 8'h00);
      want = 3'h7;
      tick(10);
      chk("irq cts", 8'h01, {7'h00, irq});
      pick(UHPM_IDX_MSR);
      rreg("msr cts", 1'b1, 8'hB1);
      // Each datapath source: masked, then enabled, then removed
      for (int i = 0; i < 4; i++) begin
         wreg(UHPM_IDX_IER, 8'h00);
         {rxe, rxa, rxt, thr} = 4'h8 >> i;
         tick(4);
         chk("irq masked", 8'h00, {7'h00, irq});
         wreg(UHPM_IDX_IER, ien[i]);
         chk("irq source", 8'h01, {7'h00, irq});
         {rxe, rxa, rxt, thr} = 4'h0;
         tick(4);
         chk("irq removed", 8'h00, {7'h00, irq});
      end
      // Latched select survives pin changes while the strobe is high
      pick(UHPM_IDX_MSR);
      ads_n = 1'b1;
      tick(5);
      sel = 3'h0;
      cs_a = 1'b0;
      tick(5);
      rreg("latched msr", 1'b1, 8'hB0);
      // Divisor of three: two high cycles in every three
      wreg(UHPM_IDX_LCR, 8'h80);
      wreg(UHPM_IDX_DIV_LO, 8'h03);
      wreg(UHPM_IDX_DIV_HI, 8'h00);
      wreg(UHPM_IDX_LCR, 8'h00);
      hi = 8'h00;
      repeat (30) begin
         tick(1);
         hi = hi + {7'h00, baud};
      end
      chk("baud high count", 8'h14, hi);
      finish_test();
   end
endmodule
